// ==== rtl/cttm_pkg.sv ====
package cttm_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses, one aligned word each)
	// ------------------------------------------------------------
	localparam logic [4:0] ADDR_CONTROL_0  = 5'h00;
	localparam logic [4:0] ADDR_CONTROL_1  = 5'h04;
	localparam logic [4:0] ADDR_COUNT_LO   = 5'h08;
	localparam logic [4:0] ADDR_COUNT_HI   = 5'h0C;
	localparam logic [4:0] ADDR_MATCH_A_LO = 5'h10;
	localparam logic [4:0] ADDR_MATCH_A_HI = 5'h14;
	localparam logic [4:0] ADDR_FLAGS      = 5'h18;

	localparam logic [7:0] CONTROL_0_RST = 8'h00;
	localparam logic [7:0] CONTROL_1_RST = 8'h00;
	localparam logic [9:0] MATCH_A_RST   = 10'h000;

	// ------------------------------------------------------------
	// control 0 fields
	// ------------------------------------------------------------
	localparam int C0_PAUSE_BIT   = 7;
	localparam int C0_CLK_LSB     = 4;
	localparam int C0_ON_BIT      = 3;
	localparam int C0_PERIOD_LSB  = 0;

	// ------------------------------------------------------------
	// control 1 fields
	// ------------------------------------------------------------
	localparam int C1_MODE_LSB    = 6;
	localparam int C1_ACTION_LSB  = 4;
	localparam int C1_LEVEL_BIT   = 3;
	localparam int C1_INVERT_BIT  = 2;
	localparam int C1_SWAP_BIT    = 1;
	localparam int C1_CLRSRC_BIT  = 0;

	// flags register: bit 0 match a, bit 1 match p, write 1 to clear
	localparam int FLAG_A_BIT     = 0;
	localparam int FLAG_P_BIT     = 1;

	// ------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_COMPARE = 2'h0;
	localparam logic [1:0] MODE_PWM     = 2'h2;
	localparam logic [1:0] MODE_TIMER   = 2'h3;

	localparam logic [2:0] CLK_SYS_DIV4  = 3'h0;
	localparam logic [2:0] CLK_SYS       = 3'h1;
	localparam logic [2:0] CLK_FAST_16   = 3'h2;
	localparam logic [2:0] CLK_FAST_64   = 3'h3;
	localparam logic [2:0] CLK_SLOW_A    = 3'h4;
	localparam logic [2:0] CLK_SLOW_B    = 3'h5;
	localparam logic [2:0] CLK_PIN_RISE  = 3'h6;
	localparam logic [2:0] CLK_PIN_FALL  = 3'h7;

	localparam logic [1:0] ACT_NONE   = 2'h0;
	localparam logic [1:0] ACT_LOW    = 2'h1;
	localparam logic [1:0] ACT_HIGH   = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;

	localparam logic [9:0] COUNT_MAX  = 10'h3FF;

	// prescaler terminal counts
	localparam logic [5:0] DIV4_LAST  = 6'h03;
	localparam logic [5:0] DIV16_LAST = 6'h0F;
	localparam logic [5:0] DIV64_LAST = 6'h3F;

	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef struct packed {
		logic [1:0] mode;
		logic [1:0] action;
		logic       level;
		logic       invert;
		logic       swap;
		logic       clrsrc;
	} cttm_ctl1_type;

endpackage : cttm_pkg

// ==== rtl/cttm_edge_sync.sv ====
`timescale 1ns/1ps
module cttm_edge_sync (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_pin,
	output logic      o_rise,
	output logic      o_fall
);
	logic meta_q;
	logic sync_q;
	logic last_q;

	// meta_q feeds only sync_q
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= i_pin;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign o_rise = sync_q & ~last_q;
	assign o_fall = ~sync_q & last_q;
endmodule : cttm_edge_sync

// ==== rtl/cttm_timer.sv ====
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - counter cleared on counter_on rising edge
// - auto clear on overflow or match
// - count read-only, compare a read/write
// - pause_ctl freezes counter
// - clock_sel picks count clock source
// - counter_on low stops, holds count
// - compare mode pin reset on enable
// - period compare on counter bits 9:7
// - period zero means overflow clear
// - op_mode_sel decodes three modes
// - timer mode leaves pin undriven
// - compare match pin action select
// - pwm pin action select
// - same level gives no visible change
// - output_level_ctl initial or active level
// - output_invert inverts the pin
// - duty_period_swap swaps duty and period
// - clear_source_sel picks clear source
// - unimplemented high bits read zero
// - low bytes go through shared buffer
// - clear on a raises only match_a_flag
// - duty at least period gives 100%
module cttm_timer
	import cttm_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        i_fast_clk_tick,
	input  wire logic        i_slow_clk_tick,
	input  wire logic        i_ext_count_pin,
	output logic             o_timer_output_pin,
	output logic             o_timer_output_pin_oe_n,
	output logic             o_match_a_flag,
	output logic             o_match_p_flag
);
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0]    ctl0_q;
	cttm_ctl1_type ctl1_q;
	logic [9:0]    match_a_q;
	logic [7:0]    buf_q;
	logic [9:0]    count_q;
	logic [9:0]    count_d;
	logic [5:0]    sys_div_q;
	logic [5:0]    fast_div_q;
	logic          pin_q;
	logic          pwm_q;
	logic          flag_a_q;
	logic          flag_p_q;
	logic          on_last_q;

	logic [4:0]    aw_addr_q;
	logic          aw_have_q;
	logic [31:0]   w_data_q;
	logic [3:0]    w_strb_q;
	logic          w_have_q;
	logic          bvalid_q;
	logic [1:0]    bresp_q;
	logic          rvalid_q;
	logic [31:0]   rdata_q;
	logic [1:0]    rresp_q;

	// ------------------------------------------------------------
	// field decode
	// ------------------------------------------------------------
	wire       pause_ctl      = ctl0_q[C0_PAUSE_BIT];
	wire [2:0] clock_sel      = ctl0_q[C0_CLK_LSB +: 3];
	wire       counter_on     = ctl0_q[C0_ON_BIT];
	wire [2:0] compare_p_value = ctl0_q[C0_PERIOD_LSB +: 3];
	wire       on_rise        = counter_on & ~on_last_q;

	wire mode_compare = (ctl1_q.mode == MODE_COMPARE);
	wire mode_pwm     = (ctl1_q.mode == MODE_PWM);
	wire mode_timer   = (ctl1_q.mode == MODE_TIMER);

	// ------------------------------------------------------------
	// count clock selection
	// ------------------------------------------------------------
	logic ext_rise;
	logic ext_fall;

	cttm_edge_sync u_edge_sync (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_pin   (i_ext_count_pin),
		.o_rise  (ext_rise),
		.o_fall  (ext_fall)
	);

	wire sys4_tick  = (sys_div_q == DIV4_LAST);
	wire fast16_tick = i_fast_clk_tick && (fast_div_q[3:0] == DIV16_LAST[3:0]);
	wire fast64_tick = i_fast_clk_tick && (fast_div_q == DIV64_LAST);

	wire tick = (clock_sel == CLK_SYS_DIV4) ? sys4_tick :
	            (clock_sel == CLK_SYS)      ? 1'b1 :
	            (clock_sel == CLK_FAST_16)  ? fast16_tick :
	            (clock_sel == CLK_FAST_64)  ? fast64_tick :
	            (clock_sel == CLK_PIN_RISE) ? ext_rise :
	            (clock_sel == CLK_PIN_FALL) ? ext_fall :
	            i_slow_clk_tick;

	// run only when on and not paused
	wire step = counter_on & ~pause_ctl & tick & ~on_rise;

	// ------------------------------------------------------------
	// comparators
	// ------------------------------------------------------------
	// a match is judged on the count reached after the step
	wire [9:0] next_count = count_q + 10'h001;
	wire       p_is_zero  = (compare_p_value == 3'h0);
	wire       match_p    = step && !p_is_zero &&
	                        (next_count[9:7] == compare_p_value) &&
	                        (next_count[6:0] == 7'h00);
	wire       match_a    = step && (match_a_q != 10'h000) &&
	                        (next_count == match_a_q);
	wire       overflow   = step && (count_q == COUNT_MAX);

	// pwm: period and duty roles
	wire [10:0] p_len   = p_is_zero ? 11'h400 : {1'b0, compare_p_value, 7'h00};
	wire [10:0] a_len   = {1'b0, match_a_q};
	wire [10:0] per_len = ctl1_q.swap ? a_len : p_len;
	wire [10:0] dut_len = ctl1_q.swap ? p_len : a_len;
	wire        per_hit = step && ({1'b0, next_count} == per_len);

	wire clear_now = mode_pwm ? (per_hit || overflow) :
	                 ctl1_q.clrsrc ? match_a :
	                 (match_p || overflow);

	wire set_a = mode_pwm ? (ctl1_q.swap ? per_hit : match_a) :
	             match_a;
	wire set_p = mode_pwm ? (ctl1_q.swap ? match_p : per_hit) :
	             (~ctl1_q.clrsrc & match_p);

	always_comb begin
		count_d = count_q;
		if (on_rise)
			count_d = 10'h000;
		else if (clear_now)
			count_d = 10'h000;
		else if (step)
			count_d = next_count;
	end

	// pwm active while count below duty, full duty when duty >= period
	wire pwm_active = (dut_len >= per_len) || ({1'b0, count_d} < dut_len);

	// ------------------------------------------------------------
	// output pin
	// ------------------------------------------------------------
	logic pin_d;
	always_comb begin
		pin_d = pin_q;
		if (on_rise)
			pin_d = ctl1_q.level;
		else if (mode_compare && match_a) begin
			unique case (ctl1_q.action)
				ACT_NONE:   pin_d = pin_q;
				ACT_LOW:    pin_d = 1'b0;
				ACT_HIGH:   pin_d = 1'b1;
				ACT_TOGGLE: pin_d = ~pin_q;
			endcase
		end
	end

	// active level follows output_level_ctl; action 11 treated as inactive
	wire pwm_raw = (ctl1_q.action == ACT_LOW)  ? 1'b1 :
	               (ctl1_q.action == ACT_HIGH) ? pwm_active : 1'b0;
	wire pwm_lvl = ctl1_q.level ? pwm_raw : ~pwm_raw;
	wire pin_src = mode_pwm ? pwm_q : pin_q;

	assign o_timer_output_pin      = pin_src ^ ctl1_q.invert;
	assign o_timer_output_pin_oe_n = mode_timer | (ctl1_q.mode == 2'h1);
	assign o_match_a_flag          = flag_a_q;
	assign o_match_p_flag          = flag_p_q;

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	wire wr_go = aw_have_q && w_have_q && !bvalid_q;
	wire rd_go = s_axi_arvalid && !rvalid_q;
	wire [7:0] wbyte = w_data_q[7:0];
	wire wr_lane = w_strb_q[0];

	wire wr_c0   = wr_go && wr_lane && (aw_addr_q == ADDR_CONTROL_0);
	wire wr_c1   = wr_go && wr_lane && (aw_addr_q == ADDR_CONTROL_1);
	wire wr_alo  = wr_go && wr_lane && (aw_addr_q == ADDR_MATCH_A_LO);
	wire wr_ahi  = wr_go && wr_lane && (aw_addr_q == ADDR_MATCH_A_HI);
	wire wr_flg  = wr_go && wr_lane && (aw_addr_q == ADDR_FLAGS);
	wire wr_map  = (aw_addr_q <= ADDR_FLAGS) && (aw_addr_q != ADDR_COUNT_LO) &&
	               (aw_addr_q != ADDR_COUNT_HI);

	wire rd_chi  = rd_go && (s_axi_araddr == ADDR_COUNT_HI);
	wire rd_ahi  = rd_go && (s_axi_araddr == ADDR_MATCH_A_HI);
	wire rd_map  = (s_axi_araddr <= ADDR_FLAGS);

	// low byte reads come from the shared buffer, high reads fill it
	wire [7:0] rd_byte =
		(s_axi_araddr == ADDR_CONTROL_0)  ? ctl0_q :
		(s_axi_araddr == ADDR_CONTROL_1)  ? ctl1_q :
		(s_axi_araddr == ADDR_COUNT_LO)   ? buf_q :
		(s_axi_araddr == ADDR_COUNT_HI)   ? {6'h00, count_q[9:8]} :
		(s_axi_araddr == ADDR_MATCH_A_LO) ? buf_q :
		(s_axi_araddr == ADDR_MATCH_A_HI) ? {6'h00, match_a_q[9:8]} :
		(s_axi_araddr == ADDR_FLAGS)      ? {6'h00, flag_p_q, flag_a_q} :
		8'h00;

	assign s_axi_awready = !aw_have_q;
	assign s_axi_wready  = !w_have_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 5'h00;
			w_have_q  <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= AXI_OKAY;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= AXI_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_have_q) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_have_q <= 1'b0;
			end
			if (s_axi_wvalid && !w_have_q) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_go) begin
				w_have_q <= 1'b0;
			end
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_map ? AXI_OKAY : AXI_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
			if (rd_go) begin
				rvalid_q <= 1'b1;
				rdata_q  <= {24'h000000, rd_byte};
				rresp_q  <= rd_map ? AXI_OKAY : AXI_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// timer state
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			ctl0_q     <= CONTROL_0_RST;
			ctl1_q     <= CONTROL_1_RST;
			match_a_q  <= MATCH_A_RST;
			buf_q      <= 8'h00;
			count_q    <= 10'h000;
			sys_div_q  <= 6'h00;
			fast_div_q <= 6'h00;
			pin_q      <= 1'b0;
			pwm_q      <= 1'b0;
			flag_a_q   <= 1'b0;
			flag_p_q   <= 1'b0;
			on_last_q  <= 1'b0;
		end else begin
			on_last_q <= counter_on;
			if (wr_c0)
				ctl0_q <= wbyte;
			if (wr_c1)
				ctl1_q <= wbyte;
			// high write commits buffer to low byte
			if (wr_ahi)
				match_a_q <= {wbyte[1:0], buf_q};
			if (wr_alo)
				buf_q <= wbyte;
			else if (rd_chi)
				buf_q <= count_q[7:0];
			else if (rd_ahi)
				buf_q <= match_a_q[7:0];
			sys_div_q  <= sys4_tick ? 6'h00 : sys_div_q + 6'h01;
			if (i_fast_clk_tick)
				fast_div_q <= fast_div_q + 6'h01;
			count_q <= count_d;
			pin_q   <= pin_d;
			pwm_q   <= pwm_lvl;
			// hardware set beats software clear
			flag_a_q <= set_a | (flag_a_q & ~(wr_flg & wbyte[FLAG_A_BIT]));
			flag_p_q <= set_p | (flag_p_q & ~(wr_flg & wbyte[FLAG_P_BIT]));
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_enable_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$rose(counter_on) |=> count_q == 10'h000)
		else $error("count not cleared on enable");

	a_pause_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		pause_ctl && $past(pause_ctl) && !on_rise |=> $stable(count_q))
		else $error("count moved while paused");

	a_off_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!counter_on |=> count_q == $past(count_q))
		else $error("count moved while off");

	a_pclear_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!mode_pwm && ctl1_q.clrsrc |=> !$rose(flag_p_q))
		else $error("p flag raised while clear on a");

	a_sys_count: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		step && !clear_now && !on_rise |=> count_q == $past(count_q) + 10'h001)
		else $error("count did not step");

	a_timer_oe: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_timer_output_pin_oe_n == ctl1_q.mode[0])
		else $error("pin drive wrong for mode");

	a_init_level: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		on_rise && mode_compare |=> o_timer_output_pin == (ctl1_q.level ^ ctl1_q.invert))
		else $error("initial level wrong");

	a_high_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits nonzero");

	a_count_hi_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		rd_chi |=> s_axi_rdata[7:0] == {6'h00, $past(count_q[9:8])})
		else $error("count high read wrong");
endmodule : cttm_timer

// ==== bench/cttm_pin_src.sv ====
`timescale 1ns/1ps
module cttm_pin_src (
	input  wire logic i_clk,
	output logic      o_pin
);
	// ----
	// count pin source
	// ----
	// idles low; w of 3 or more keeps each level past the two-flop sync
	initial o_pin = 1'b0;

	task automatic pulses(input int n, input int w);
		repeat (n) begin
			repeat (w) @(posedge i_clk);
			o_pin <= 1'b1;
			repeat (w) @(posedge i_clk);
			o_pin <= 1'b0;
		end
		repeat (8) @(posedge i_clk);
	endtask : pulses
endmodule : cttm_pin_src

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
	import cttm_pkg::*;
;
	logic        clk, rst_n, aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
	logic        fast, slow, ext, pin, oe_n, fa, fp;
	logic [4:0]  awa, ara;
	logic [3:0]  ws;
	logic [31:0] wd, rdat, v;
	logic [1:0]  bresp, rresp;
	int          mismatches, n_compared;

	cttm_timer i_cttm_timer (
		.i_clk(clk), .i_rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(aw_v),
		.s_axi_awready(aw_r), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(w_v),
		.s_axi_wready(w_r), .s_axi_bresp(bresp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
		.s_axi_araddr(ara), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
		.s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
		.i_fast_clk_tick(fast), .i_slow_clk_tick(slow), .i_ext_count_pin(ext),
		.o_timer_output_pin(pin), .o_timer_output_pin_oe_n(oe_n),
		.o_match_a_flag(fa), .o_match_p_flag(fp)
	);
	cttm_pin_src i_cttm_pin_src (.i_clk(clk), .o_pin(ext));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ----
	// checking and closing
	// ----
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected %s expected %0h seen %0h", nm, e, s);
		end
	endtask : chk

	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : summarize

	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		summarize();
	end

	// ----
	// bus master and stimulus
	// ----
	task automatic axw(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
		int t;
		@(posedge clk);
		t = 0;
		awa <= a;
		wd <= {24'h0, d};
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		do begin
			@(posedge clk);
			t++;
			if (aw_r) aw_v <= 1'b0;
			if (w_r) w_v <= 1'b0;
		end while (!b_v && t < 50);
		b_r <= 1'b0;
		chk("bvalid", 32'(b_v), 32'h1);
		chk("bresp", 32'(bresp), 32'(er));
	endtask : axw

	task automatic axr(input logic [4:0] a, input logic [1:0] er, output logic [31:0] d);
		int t;
		@(posedge clk);
		t = 0;
		ara <= a;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		do begin
			@(posedge clk);
			t++;
			if (ar_r) ar_v <= 1'b0;
			d = rdat;
		end while (!r_v && t < 50);
		r_r <= 1'b0;
		chk("rvalid", 32'(r_v), 32'h1);
		chk("rresp", 32'(rresp), 32'(er));
	endtask : axr

	task automatic rc(input string nm, input logic [4:0] a, input logic [31:0] e);
		logic [31:0] d;
		axr(a, AXI_OKAY, d);
		chk(nm, d, e);
	endtask : rc

	// high byte first: it latches the low byte, so a moving count reads coherently
	task automatic cnt(input int e, output int c);
		logic [31:0] h;
		logic [31:0] l;
		axr(ADDR_COUNT_HI, AXI_OKAY, h);
		axr(ADDR_COUNT_LO, AXI_OKAY, l);
		c = int'({h[1:0], l[7:0]});
		if (e >= 0) begin
			chk("count_hi", h, 32'(e >> 8));
			chk("count_lo", l, 32'(e % 256));
		end
	endtask : cnt

	task automatic tk(input int n);
		repeat (n) begin
			@(posedge clk);
			slow <= 1'b1;
			@(posedge clk);
			slow <= 1'b0;
		end
		repeat (3) @(posedge clk);
	endtask : tk

	task automatic cfg(input logic [7:0] c0, input logic [7:0] c1, input logic [9:0] a);
		axw(ADDR_CONTROL_0, c0 & 8'hF7, AXI_OKAY);
		axw(ADDR_CONTROL_1, c1, AXI_OKAY);
		axw(ADDR_MATCH_A_LO, a[7:0], AXI_OKAY);
		axw(ADDR_MATCH_A_HI, {6'h0, a[9:8]}, AXI_OKAY);
		axw(ADDR_FLAGS, 8'h03, AXI_OKAY);
		axw(ADDR_CONTROL_0, c0, AXI_OKAY);
		// enable edge lands on the edge the write returns on; let it settle
		@(posedge clk);
	endtask : cfg

	// ----
	// tests
	// ----
	initial begin
		int c, e, a, l, n, k;
		int dv[4];
		int rows[8][6];
		dv = '{4, 1, 16, 64};
		// act, swap, period code, a value, ticks, active
		rows = '{'{2, 0, 1, 3, 2, 1}, '{2, 0, 1, 3, 5, 0}, '{2, 0, 1, 3, 128, 1},
			'{2, 0, 1, 128, 127, 1}, '{2, 1, 1, 200, 100, 1}, '{2, 1, 1, 200, 130, 0},
			'{0, 0, 1, 3, 2, 0}, '{1, 0, 1, 3, 5, 1}};
		{rst_n, aw_v, w_v, b_r, ar_v, r_r, fast, slow} = 8'h00;
		{awa, ara, wd} = 42'h0;
		ws = 4'hF;
		void'($urandom(32'h7613));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		fast <= 1'b1;
		for (k = 0; k < 6; k++) rc("reset", 5'(k * 4), 32'h0);
		axr(5'h1C, AXI_SLVERR, v);
		axw(ADDR_COUNT_LO, 8'hFF, AXI_SLVERR);
		cnt(0, c);
		$display("test registers done");
		a = $urandom % 1024;
		axw(ADDR_MATCH_A_LO, 8'(a), AXI_OKAY);
		axw(ADDR_MATCH_A_HI, 8'(a >> 8), AXI_OKAY);
		rc("a_hi", ADDR_MATCH_A_HI, 32'(a >> 8));
		rc("a_lo", ADDR_MATCH_A_LO, 32'(a % 256));
		axw(ADDR_MATCH_A_LO, 8'h5A, AXI_OKAY);
		rc("count_hi", ADDR_COUNT_HI, 32'h0);
		axw(ADDR_MATCH_A_HI, 8'h01, AXI_OKAY);
		rc("a_lo", ADDR_MATCH_A_LO, 32'h0);
		ws <= 4'h0;
		axw(ADDR_CONTROL_1, 8'hFF, AXI_OKAY);
		ws <= 4'hF;
		rc("ctl1", ADDR_CONTROL_1, 32'h0);
		$display("test buffer done");
		for (k = 0; k < 8; k++) begin
			cfg({1'b0, 3'(k), 4'h8}, 8'h00, 10'h000);
			if (k < 4) begin
				repeat (512) @(posedge clk);
				axw(ADDR_CONTROL_0, {1'b1, 3'(k), 4'h8}, AXI_OKAY);
				cnt(-1, c);
				e = 512 / dv[k];
				chk("rate", 32'(c >= e - 2 && c <= e + 2 + 8 / dv[k]), 32'h1);
			end else begin
				if (k < 6) tk(3);
				else i_cttm_pin_src.pulses(3, 3 + $urandom % 4);
				cnt(3, c);
			end
		end
		$display("test clock select done");
		cfg({1'b0, CLK_SLOW_A, 4'h8}, 8'h00, 10'h000);
		tk(5);
		axw(ADDR_CONTROL_0, {1'b1, CLK_SLOW_A, 4'h8}, AXI_OKAY);
		tk(3);
		cnt(5, c);
		axw(ADDR_CONTROL_0, {1'b0, CLK_SLOW_A, 4'h8}, AXI_OKAY);
		tk(2);
		cnt(7, c);
		axw(ADDR_CONTROL_0, {1'b0, CLK_SLOW_A, 4'h0}, AXI_OKAY);
		tk(3);
		cnt(7, c);
		axw(ADDR_CONTROL_0, {1'b0, CLK_SLOW_A, 4'h8}, AXI_OKAY);
		cnt(0, c);
		$display("test pause and enable done");
		for (k = 0; k < 8; k++) begin
			e = (k == 0) ? 1024 : k * 128;
			cfg({1'b0, CLK_SLOW_A, 1'b1, 3'(k)}, 8'h00, 10'h000);
			tk(e - 1);
			cnt(e - 1, c);
			rc("flags", ADDR_FLAGS, 32'h0);
			tk(1);
			cnt(0, c);
			if (k != 0) rc("flags", ADDR_FLAGS, 32'h2);
		end
		$display("test period done");
		for (k = 0; k < 4; k++) begin
			l = $urandom % 2;
			n = $urandom % 2;
			c = k % 2; // both clear sources, so the a-clear path is hit for k of 1 and 3
			a = 2 + $urandom % 20;
			cfg({1'b0, CLK_SLOW_A, 4'h9},
				{MODE_COMPARE, 2'(k), 1'(l), 1'(n), 1'b0, 1'(c)}, 10'(a));
			chk("pin", 32'(pin), 32'(l ^ n));
			chk("oe_n", 32'(oe_n), 32'h0);
			tk(a);
			cnt(c ? 0 : a, e);
			chk("flag_a", 32'(fa), 32'h1);
			chk("flag_p", 32'(fp), 32'h0);
			e = (k == 0) ? l : (k == 3) ? 1 - l : k - 1;
			chk("pin", 32'(pin), 32'(e ^ n));
		end
		$display("test compare done");
		for (k = 0; k < 4; k++) begin
			cfg({1'b0, CLK_SLOW_A, 4'h8}, {2'(k), 6'h3C}, 10'h005);
			chk("oe_n", 32'(oe_n), 32'(k % 2));
		end
		$display("test modes done");
		for (k = 0; k < 8; k++) begin
			l = $urandom % 2;
			n = $urandom % 2;
			cfg({1'b0, CLK_SLOW_A, 1'b1, 3'(rows[k][2])},
				{MODE_PWM, 2'(rows[k][0]), 1'(l), 1'(n), 1'(rows[k][1]), 1'b1},
				10'(rows[k][3]));
			tk(rows[k][4]);
			e = rows[k][5] ? l : 1 - l;
			chk("pwm_pin", 32'(pin), 32'(e ^ n));
		end
		$display("test pwm done");
		summarize();
	end
endmodule : tb_top
